// *** rtl/ack_wait_pkg.sv ***
// Notes on behaviour
// (RULE1) With acknowledge termination on, a cycle not ended by the acknowledge within 1024 clocks flags a bus error.
// (RULE2) Two acknowledge modes exist: rising-edge termination, or level sampling after an insensitivity window.
// (RULE3) The acknowledge only acts on asynchronous transfers, so synchronous mode must be off for its chip select.
// (RULE4) In edge mode a rising acknowledge edge before the time-out completes the transfer.
// (RULE5) In edge mode the external device must raise its acknowledge before 1024 clocks or the cycle errors.
// (RULE6) Edge mode is only available on chip select 5.
// (RULE7) Edge mode needs wait-state count 0x3F, assert or negate delay of at least 1, and ack glue enabled.
// (RULE8) A nonzero assert or negate delay separates back-to-back transfers so each awaits a fresh rising edge.
// (RULE9) In level mode the acknowledge is ignored for a programmed 2 to 5 clocks before sampling.
// (RULE10) In level mode a high acknowledge after the window lets the access run its programmed wait states.
// (RULE11) In level mode a low sample stalls the access until high again, bounded by the time-out.
// (RULE12) In level mode a low acknowledge at any time after the window pauses the transfer until it returns high.
// (RULE13) Level mode is usable on every chip select except 4, whose pin carries the acknowledge.
// (RULE14) Level mode needs external wait on, wait count above 1, negate delay below 3, window set, ack glue off.
// (RULE15) On a time-out the cycle ends, chip select and strobes are released, and an error returns to the master.
package ack_wait_pkg;
  localparam int timeout_cycles = 1024;
  localparam logic [5:0] edge_wsc = 6'h3f;
  localparam logic [2:0] edge_cs = 3'h5;
  localparam logic [2:0] shared_cs = 3'h4;
  localparam logic [2:0] dct_min = 3'h2;
  localparam logic [2:0] dct_max = 3'h5;
  localparam logic [1:0] csn_limit = 2'h3;
  localparam logic [5:0] level_wsc_min = 6'h2;
  localparam logic [2:0] ack_sync_reset = 3'h7;

  typedef enum logic [2:0] {st_idle, st_assert, st_insens, st_wait, st_negate, st_gap} phase_e;

  typedef struct packed {
    logic [2:0] cs;
    logic sync;
    logic [5:0] wait_state_count;
    logic [1:0] cs_assert_delay;
    logic [1:0] cs_negate_delay;
    logic ew;
    logic [2:0] ack_insensitivity_time;
    logic ack_glue_enable;
  } cs_cfg_s;

  typedef struct packed {
    logic valid;
    logic write;
  } req_s;

  typedef struct packed {
    logic done;
    logic error;
  } resp_s;
endpackage

// *** rtl/external_bus_ack_wait.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_ack_wait #(
  // time-out length in clocks
  parameter int tmo_limit = ack_wait_pkg::timeout_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // internal master side
  input wire ack_wait_pkg::req_s req,
  input wire ack_wait_pkg::cs_cfg_s cfg,
  output ack_wait_pkg::resp_s resp,
  output logic busy,
  output logic cfg_error,
  // external pins
  input wire logic xfer_acknowledge_in,
  output logic cs_active,
  output logic strobe_active
);
  typedef struct packed {
    ack_wait_pkg::phase_e phase;
    logic [10:0] tmo;
    logic [5:0] cnt;
    logic [2:0] ack_sync;
    logic ack_prev;
    logic edge_mode;
    logic write;
    ack_wait_pkg::resp_s resp;
    logic busy;
    logic cfg_error;
    logic cs_active;
    logic strobe_active;
  } state_s;

  state_s s, n;
  logic ack_hi, ack_rise, ok_edge, ok_level, tmo_hit;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the time-out counter is 11 bits wide and must outlast the assert and insensitivity phases
  if (tmo_limit < 16 || tmo_limit > 2048) begin : g_bad_tmo_limit
    $error("tmo_limit out of range");
  end

  // ----------------------------------------------------------------
  // acknowledge filtering and mode qualification
  // ----------------------------------------------------------------
  // the new level is accepted only once stages two and three agree
  assign ack_hi = (s.ack_sync[2] == s.ack_sync[1]) ? s.ack_sync[1] : s.ack_prev;
  assign ack_rise = ack_hi & ~s.ack_prev;
  assign ok_edge = cfg.ack_glue_enable && !cfg.sync && cfg.cs == ack_wait_pkg::edge_cs // [RULE3] [RULE6]
    && cfg.wait_state_count == ack_wait_pkg::edge_wsc && (cfg.cs_assert_delay != 2'h0 || cfg.cs_negate_delay != 2'h0); // [RULE7]
  assign ok_level = !cfg.ack_glue_enable && !cfg.sync && cfg.ew && cfg.cs != ack_wait_pkg::shared_cs // [RULE13]
    && cfg.wait_state_count >= ack_wait_pkg::level_wsc_min && cfg.cs_negate_delay < ack_wait_pkg::csn_limit // [RULE14]
    && cfg.ack_insensitivity_time >= ack_wait_pkg::dct_min && cfg.ack_insensitivity_time <= ack_wait_pkg::dct_max;
  assign tmo_hit = s.tmo == 11'(tmo_limit - 1);

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.ack_sync = {s.ack_sync[1:0], xfer_acknowledge_in};
    n.ack_prev = ack_hi;
    n.resp = '0;
    unique case (s.phase)
      ack_wait_pkg::st_idle: begin
        n.busy = 1'b0;
        n.tmo = '0;
        if (req.valid) begin
          n.write = req.write;
          n.busy = 1'b1;
          if (!ok_edge && !ok_level) begin
            // misprogrammed chip select: refuse without touching the bus
            n.cfg_error = 1'b1;
            n.resp.error = 1'b1;
            n.busy = 1'b0;
          end else begin
            n.cfg_error = 1'b0;
            n.edge_mode = ok_edge; // [RULE2]
            n.cs_active = 1'b1;
            n.cnt = {4'h0, cfg.cs_assert_delay};
            n.phase = ack_wait_pkg::st_assert;
          end
        end
      end
      ack_wait_pkg::st_assert: begin
        n.tmo = s.tmo + 11'h1;
        if (s.cnt == 6'h0) begin
          n.strobe_active = 1'b1;
          n.cnt = {3'h0, s.edge_mode ? 3'h0 : cfg.ack_insensitivity_time};
          n.phase = s.edge_mode ? ack_wait_pkg::st_wait : ack_wait_pkg::st_insens;
        end else begin
          n.cnt = s.cnt - 6'h1;
        end
      end
      ack_wait_pkg::st_insens: begin
        // acknowledge ignored for the programmed window
        n.tmo = s.tmo + 11'h1;
        n.cnt = s.cnt - 6'h1; // [RULE9]
        if (s.cnt == 6'h1) begin
          n.cnt = cfg.wait_state_count;
          n.phase = ack_wait_pkg::st_wait;
        end
      end
      ack_wait_pkg::st_wait: begin
        n.tmo = s.tmo + 11'h1;
        if (tmo_hit) begin
          n.phase = ack_wait_pkg::st_negate; // [RULE1] [RULE5]
          n.resp.error = 1'b1; // [RULE15]
          n.strobe_active = 1'b0;
          n.cs_active = 1'b0;
          n.cnt = 6'h0;
        end else if (s.edge_mode) begin
          if (ack_rise) begin
            n.strobe_active = 1'b0; // [RULE4]
            n.resp.done = 1'b1;
            n.cnt = {4'h0, cfg.cs_negate_delay};
            n.phase = ack_wait_pkg::st_negate;
          end
        end else if (ack_hi) begin
          // low acknowledge freezes the wait-state count
          if (s.cnt == 6'h0) begin
            n.strobe_active = 1'b0; // [RULE10]
            n.resp.done = 1'b1;
            n.cnt = {4'h0, cfg.cs_negate_delay};
            n.phase = ack_wait_pkg::st_negate;
          end else begin
            n.cnt = s.cnt - 6'h1; // [RULE11] [RULE12]
          end
        end
      end
      ack_wait_pkg::st_negate: begin
        if (s.cnt == 6'h0) begin
          n.cs_active = 1'b0;
          n.phase = ack_wait_pkg::st_gap; // [RULE8]
        end else begin
          n.cnt = s.cnt - 6'h1;
        end
      end
      ack_wait_pkg::st_gap: begin
        n.busy = 1'b0;
        n.phase = ack_wait_pkg::st_idle;
      end
      default: begin
        // an unused phase code falls back to idle with the bus released
        n.phase = ack_wait_pkg::st_idle;
        n.cs_active = 1'b0;
        n.strobe_active = 1'b0;
        n.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '{phase: ack_wait_pkg::st_idle, ack_sync: ack_wait_pkg::ack_sync_reset, ack_prev: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a register field, so nothing combinational reaches a pin
  assign resp = s.resp;
  assign busy = s.busy;
  assign cfg_error = s.cfg_error;
  assign cs_active = s.cs_active;
  assign strobe_active = s.strobe_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_timeout_bound;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait |-> int'(s.tmo) < tmo_limit;
  endproperty
  a_timeout_bound: assert property (p_timeout_bound) else $error("wait ran past time-out"); // [RULE1]
  property p_edge_only_cs5;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle && cfg.cs != 3'h5
      |=> !s.edge_mode || !s.cs_active;
  endproperty
  a_edge_only_cs5: assert property (p_edge_only_cs5) else $error("edge mode on wrong chip select"); // [RULE6]
  property p_no_cs4_level;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle && !cfg.ack_glue_enable && cfg.cs == 3'h4
      |=> !s.cs_active && s.resp.error;
  endproperty
  a_no_cs4_level: assert property (p_no_cs4_level) else $error("level mode on shared chip select"); // [RULE13]
  property p_sync_refused;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle && cfg.sync |=> s.cfg_error;
  endproperty
  a_sync_refused: assert property (p_sync_refused) else $error("synchronous chip select accepted"); // [RULE3]
  property p_edge_done;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && s.edge_mode && ack_rise && !tmo_hit
      |=> s.resp.done && !s.strobe_active;
  endproperty
  a_edge_done: assert property (p_edge_done) else $error("rising edge did not end transfer"); // [RULE4]
  property p_insens_len;
    @(posedge mclk) disable iff (rst) $rose(s.phase == ack_wait_pkg::st_insens) |-> s.cnt >= 6'h2 && s.cnt <= 6'h5;
  endproperty
  a_insens_len: assert property (p_insens_len) else $error("window out of range"); // [RULE9]
  property p_level_stall;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && !s.edge_mode && !ack_hi && !tmo_hit
      |=> s.cnt == $past(s.cnt) && !s.resp.done;
  endproperty
  a_level_stall: assert property (p_level_stall) else $error("low acknowledge did not stall"); // [RULE11]
  property p_level_run;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && !s.edge_mode && ack_hi && s.cnt != 6'h0
      && !tmo_hit |=> s.cnt == $past(s.cnt) - 6'h1;
  endproperty
  a_level_run: assert property (p_level_run) else $error("wait states did not advance"); // [RULE10] [RULE12]
  property p_timeout_release;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && tmo_hit
      |=> s.resp.error && !s.cs_active && !s.strobe_active;
  endproperty
  a_timeout_release: assert property (p_timeout_release) else $error("time-out did not release bus"); // [RULE15]
  property p_gap;
    @(posedge mclk) disable iff (rst) $fell(s.cs_active) |=> !s.cs_active;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap between transfers"); // [RULE8]

  // ----------------------------------------------------------------
  // configuration refusals and sequencing
  // ----------------------------------------------------------------
  property p_refuse_quiet;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle && !ok_edge && !ok_level
      |=> s.cfg_error && s.resp.error && !s.cs_active && !s.busy;
  endproperty
  a_refuse_quiet: assert property (p_refuse_quiet) else $error("bad configuration reached the bus"); // [RULE14]

  property p_edge_wsc;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle && cfg.ack_glue_enable && cfg.wait_state_count != 6'h3f
      |=> s.resp.error && !s.cs_active;
  endproperty
  a_edge_wsc: assert property (p_edge_wsc) else $error("edge mode ran without full wait count"); // [RULE7]

  property p_edge_delay;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle
      && cfg.ack_glue_enable && cfg.cs_assert_delay == 2'h0 && cfg.cs_negate_delay == 2'h0 |=> s.resp.error && !s.cs_active;
  endproperty
  a_edge_delay: assert property (p_edge_delay) else $error("edge mode ran without chip-select delay"); // [RULE7]

  property p_level_fields;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle
      && !cfg.ack_glue_enable && (!cfg.ew || cfg.wait_state_count < 6'h2 || cfg.cs_negate_delay == 2'h3) |=> s.resp.error && !s.cs_active;
  endproperty
  a_level_fields: assert property (p_level_fields) else $error("level mode ran with bad fields"); // [RULE14]

  property p_dct_range;
    @(posedge mclk) disable iff (rst) req.valid && s.phase == ack_wait_pkg::st_idle
      && !cfg.ack_glue_enable && (cfg.ack_insensitivity_time < 3'h2 || cfg.ack_insensitivity_time > 3'h5) |=> s.resp.error && !s.cs_active;
  endproperty
  a_dct_range: assert property (p_dct_range) else $error("level mode ran with bad window"); // [RULE9]

  property p_insens_hold;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_insens && s.cnt != 6'h1
      |=> s.phase == ack_wait_pkg::st_insens && !s.resp.done;
  endproperty
  a_insens_hold: assert property (p_insens_hold) else $error("window ended early"); // [RULE9]

  property p_edge_hold;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && s.edge_mode && !ack_rise && !tmo_hit
      |=> s.phase == ack_wait_pkg::st_wait && s.strobe_active && !s.resp.done;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge transfer ended without edge"); // [RULE4]

  property p_done_pulse;
    @(posedge mclk) disable iff (rst) s.resp.done
      |=> !s.resp.done && !s.strobe_active;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("completion held too long"); // [RULE10]

  property p_strobe_in_cs;
    @(posedge mclk) disable iff (rst) s.strobe_active
      |-> s.cs_active;
  endproperty
  a_strobe_in_cs: assert property (p_strobe_in_cs) else $error("strobe without chip select"); // [RULE15]

  property p_cs_busy;
    @(posedge mclk) disable iff (rst) s.cs_active
      |-> s.busy;
  endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("chip select while not busy"); // [RULE8]

  property p_tmo_step;
    @(posedge mclk) disable iff (rst)
      s.phase inside {ack_wait_pkg::st_assert, ack_wait_pkg::st_insens, ack_wait_pkg::st_wait}
      |=> s.tmo == $past(s.tmo) + 11'h1;
  endproperty
  a_tmo_step: assert property (p_tmo_step) else $error("time-out counter stalled"); // [RULE1]

  property p_level_release;
    @(posedge mclk) disable iff (rst) s.phase == ack_wait_pkg::st_wait && !s.edge_mode && ack_hi && s.cnt == 6'h0
      && !tmo_hit |=> s.resp.done && !s.strobe_active && s.phase == ack_wait_pkg::st_negate;
  endproperty
  a_level_release: assert property (p_level_release) else $error("wait states did not end access"); // [RULE10]

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  c_edge: cover property (@(posedge mclk) s.resp.done && s.edge_mode);
  c_stall: cover property (@(posedge mclk) s.phase == ack_wait_pkg::st_wait && !s.edge_mode && !ack_hi);
  c_level: cover property (@(posedge mclk) s.resp.done && !s.edge_mode);
  c_tmo: cover property (@(posedge mclk) s.resp.error && !s.cfg_error);
  c_cfg: cover property (@(posedge mclk) s.cfg_error);
endmodule
`default_nettype wire

// *** verif/ack_device_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ack_device_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus side
  input wire logic cs_active,
  input wire logic [7:0] ack_delay,
  // acknowledge pin
  output logic ack
);
  logic [7:0] cnt;

  // ----------------------------------------
  // acknowledge pin behaviour
  // ----------------------------------------
  // delay 0 answers at once, 8'hff never answers, anything else holds the pin low that long
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack <= 1'b1;
      cnt <= 8'h00;
    end else if (!cs_active) begin
      ack <= 1'b1; // not selected: the pin sits at its pull-up
      cnt <= 8'h00;
    end else if (ack_delay != 8'h00) begin
      cnt <= cnt + 8'h01;
      ack <= (cnt >= ack_delay) && (ack_delay != 8'hff);
    end
  end
endmodule
`default_nettype wire

// *** verif/external_bus_ack_wait_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_ack_wait_tb;
  logic mclk, rst, ack, busy, cfg_error, cs_active, strobe_active, got_err, got_done;
  ack_wait_pkg::req_s req;
  ack_wait_pkg::cs_cfg_s cfg, lv, eg, c;
  ack_wait_pkg::resp_s resp;
  logic [7:0] ack_delay;
  int num_errors, cmp_count, cyc;

  external_bus_ack_wait dut (.mclk(mclk), .rst(rst), .req(req), .cfg(cfg), .resp(resp), .busy(busy),
    .cfg_error(cfg_error), .xfer_acknowledge_in(ack), .cs_active(cs_active), .strobe_active(strobe_active));
  ack_device_model partner (.mclk(mclk), .rst(rst), .cs_active(cs_active), .ack_delay(ack_delay), .ack(ack));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task results;
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one transfer; cyc counts falling edges from the taking edge to the answer
  task xfer(input ack_wait_pkg::cs_cfg_s cc, input logic [7:0] d);
    int i;
    logic saw;
    @(negedge mclk);
    cfg = cc;
    ack_delay = d;
    req.valid = 1'b1;
    cyc = 0;
    got_err = 1'b0;
    got_done = 1'b0;
    saw = 1'b0;
    while (got_done !== 1'b1 && got_err !== 1'b1) begin
      @(negedge mclk);
      cyc++;
      if (strobe_active === 1'b1) saw = 1'b1;
      if (busy === 1'b1) req.valid = 1'b0;
      got_done = resp.done;
      got_err = resp.error;
      if (cyc > 2000) begin
        num_errors++;
        results();
      end
    end
    // refused requests never raise busy, so the request is dropped here as well
    req.valid = 1'b0;
    check("released", {cs_active, strobe_active}, got_done ? 2'b10 : 2'b00);
    check("strobe seen", saw, cyc > 3);
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge mclk);
    check("busy cleared", busy, 1'b0);
    repeat (3) @(negedge mclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    cfg = '0;
    ack_delay = 8'h00;
    num_errors = 0;
    cmp_count = 0;
    lv = '{cs:3'h1, sync:1'b0, wait_state_count:6'h02, cs_assert_delay:2'h0, cs_negate_delay:2'h0, ew:1'b1, ack_insensitivity_time:3'h2, ack_glue_enable:1'b0};
    eg = '{cs:3'h5, sync:1'b0, wait_state_count:6'h3f, cs_assert_delay:2'h1, cs_negate_delay:2'h1, ew:1'b0, ack_insensitivity_time:3'h0, ack_glue_enable:1'b1};
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check("idle outputs", {busy, cs_active, strobe_active, cfg_error, resp}, 6'h00);
    for (int d = 2; d <= 5; d++) begin
      c = lv;
      c.ack_insensitivity_time = 3'(d);
      xfer(c, 8'h00);
      check("level latency", cyc, 32'(5 + d));
      check("level cfg ok", {got_done, cfg_error}, 2'b10);
    end
    c = lv;
    c.cs_assert_delay = 2'h1;
    c.wait_state_count = 6'h03;
    xfer(c, 8'h00);
    check("wait states", cyc, 32'd9);
    xfer(lv, 8'd30);
    check("stall done", got_done, 1'b1);
    check("stall long", cyc > 30, 1'b1);
    xfer(lv, 8'hff);
    check("level timeout", {got_err, cyc >= 1020 && cyc <= 1030}, 2'b11);
    repeat (2) begin
      xfer(eg, 8'd20);
      check("edge done", {got_done, cyc > 20}, 2'b11);
    end
    xfer(eg, 8'hff);
    check("edge timeout", {got_err, cyc >= 1020 && cyc <= 1030}, 2'b11);
    for (int k = 0; k < 7; k++) begin
      c = (k < 3) ? eg : lv;
      case (k)
        0: c.cs = 3'h3;
        1: c.wait_state_count = 6'h3e;
        2: c.sync = 1'b1;
        3: c.cs = 3'h4;
        4: c.wait_state_count = 6'h01;
        5: c.ack_insensitivity_time = 3'h1;
        default: c.cs_negate_delay = 2'h3;
      endcase
      xfer(c, 8'h00);
      check("refusal", {got_err, cfg_error, cyc <= 3}, 3'b111);
    end
    xfer(lv, 8'h00);
    check("cfg error cleared", {got_done, cfg_error}, 2'b10);
    results();
  end
endmodule
`default_nettype wire
